// ### usb_cfg_map.svh
//
// Purpose: offsets, field positions, reset values and timing counts of the config block
// Assumes: clock of 200 MHz on both ends
// Notes: definitions only
//
`ifndef USB_CFG_MAP_SVH
`define USB_CFG_MAP_SVH

// ****************************************
// command codes on the parallel link
// ****************************************
`define CMD_HWCFG_WR 8'hBA
`define CMD_HWCFG_RD 8'hBB
`define CMD_IRQEN_WR 8'hC2
`define CMD_IRQEN_RD 8'hC3
`define CMD_MODE_WR 8'hB8
`define CMD_MODE_RD 8'hB9
`define CMD_DEV_RESET 8'hF6

// ****************************************
// hardware configuration fields
// ****************************************
`define HW_EXTERNAL_PULLUP_SELECT 14
`define HW_SLOW_CLOCK_DISABLE 13
`define HW_CLOCKS_ALWAYS_ON 12
`define HW_DIV_HI 11
`define HW_DIV_LO 8
`define HW_ACK_ONLY_DMA_MODE 7
`define HW_DMA_REQUEST_POLARITY 6
`define HW_DMA_ACK_POLARITY 5
`define HW_END_OF_TRANSFER_POLARITY 4
`define HW_WAKE_ON_SELECT 3
`define HW_SUSPEND_POWER_OFF 2
`define HW_IRQ_PULSE_MODE 1
`define HW_IRQ_POLARITY 0
`define HW_RESET 16'h2340
`define DIV_RESET 4'h3

// ****************************************
// interrupt enable and mode fields
// ****************************************
`define IE_RESET 32'h0000_0000
`define IE_USED_MASK 24'hFF_FF3F
`define MODE_RESET 8'h00
`define MODE_SOFT_ATTACH_ENABLE 0
`define MODE_GLOBAL_IRQ_ENABLE 3
`define MODE_SUSPEND_TRIGGER 5

// ****************************************
// controller registers on wishbone
// ****************************************
`define HOST_CTRL 8'h00
`define HOST_WDATA 8'h04
`define HOST_RDATA 8'h08
`define HOST_STATUS 8'h0C

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 5
`define SUSPEND_DELAY_NS 2000000
`define SUSPEND_DELAY_CYC (`SUSPEND_DELAY_NS / `CLK_PERIOD_NS)
`define LAZY_PERIOD_NS 10000
`define LAZY_HALF_CYC (`LAZY_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define IRQ_PULSE_NS 166
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### usb_cfg_pkg.sv
//
// Purpose: shared types and byte helpers of the config link
// Assumes: nothing
// Notes: byte index 0 is the low byte
//
package usb_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [23:0] irq_vec_t;
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_HW = 2'h1,
    SEL_IE = 2'h2,
    SEL_MODE = 2'h3
  } reg_sel_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SEND = 2'h1,
    H_WAIT = 2'h2
  } host_state_t;

  function automatic logic [31:0] put_byte(input logic [31:0] v, input logic [1:0] i,
                                           input byte_t b);
    logic [31:0] r;
    r = v;
    r[{i, 3'h0} +: 8] = b;
    return r;
  endfunction : put_byte

  function automatic byte_t get_byte(input logic [31:0] v, input logic [1:0] i);
    return v[{i, 3'h0} +: 8];
  endfunction : get_byte
endpackage : usb_cfg_pkg

// ### usb_cfg_link_if.sv
//
// Purpose: byte-wide command link between controller and device
// Assumes: both ends on one clock
// Notes: one req pulse per byte, ack one cycle later
//
`timescale 1ns/100ps
interface usb_cfg_link_if;
  logic req;
  logic is_cmd;
  logic wr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev(input req, input is_cmd, input wr, input wdata, output ack, output rdata);
  modport host(output req, output is_cmd, output wr, output wdata, input ack, input rdata);
endinterface : usb_cfg_link_if

// ### clk_out_div.sv
//
// Purpose: divided clock output, period of div+1 reference ticks
// Assumes: i_ref_tick is a one-cycle pulse at the reference rate
// Notes: a divider of 0 holds the output high, as one tick is the shortest period
//
`timescale 1ns/100ps
`include "usb_cfg_map.svh"
module clk_out_div (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_ref_tick,
  input wire logic [3:0] i_div,
  output logic o_clk
);
  logic [3:0] cnt_r;
  logic [3:0] div_r;
  logic out_r;

  // new divider is taken only at a period boundary, so no runt pulse appears
  wire wrap = (cnt_r >= div_r);
  wire [3:0] div_nxt = wrap ? i_div : div_r;
  wire [3:0] cnt_nxt = wrap ? 4'h0 : cnt_r + 4'h1;
  wire [4:0] half = ({1'b0, div_nxt} + 5'h2) >> 1;
  wire out_nxt = ({1'b0, cnt_nxt} < half);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 4'h0;
      div_r <= `DIV_RESET;
      out_r <= 1'b0;
    end else if (!i_run) begin
      cnt_r <= 4'h0;
      div_r <= i_div;
      out_r <= 1'b0;
    end else if (i_ref_tick) begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      out_r <= out_nxt;
    end
  end

  assign o_clk = out_r;
endmodule : clk_out_div

// ### usb_cfg_dev.sv
//
// Purpose: device end: hardware configuration, interrupt enable and mode registers
// Assumes: controller keeps the byte protocol of the link
// Notes: settings drive pull-up, clock output, suspend, dma pins and interrupt pin
`timescale 1ns/100ps
`include "usb_cfg_map.svh"
module usb_cfg_dev #(
  parameter int SUSPEND_DELAY_CYC = `SUSPEND_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  usb_cfg_link_if.dev link,
  input wire logic i_ref_tick,
  input wire usb_cfg_pkg::irq_vec_t i_irq_events,
  input wire logic i_usb_bus_reset,
  input wire logic i_usb_resume,
  input wire logic i_vbus,
  input wire logic i_cs_n,
  input wire logic i_dma_req,
  input wire logic i_dma_ack_line,
  input wire logic i_end_of_transfer_line,
  output logic o_clock_output_pin,
  output logic o_dp_pullup_en,
  output logic o_external_pullup,
  output logic o_ack_only_dma,
  output logic o_suspend_pin,
  output logic o_suspended,
  output logic o_clocks_stopped,
  output logic o_remote_wakeup,
  output logic o_irq_line,
  output logic o_dma_request_line,
  output logic o_dma_ack_active,
  output logic o_transfer_end
);
  import usb_cfg_pkg::*;

  // ****************************************
  // registers and link decode
  // ****************************************
  logic [15:0] hwcfg_r;
  logic [31:0] ie_r;
  logic [7:0] mode_r;
  reg_sel_t sel_r;
  logic dir_wr_r;
  logic [1:0] idx_r;
  logic in_range_r;
  logic ack_r;
  byte_t rdata_r;

  wire cmd_take = link.req & link.is_cmd;
  wire data_wr = link.req & ~link.is_cmd & link.wr;
  wire data_rd = link.req & ~link.is_cmd & ~link.wr;
  wire soft_reset = cmd_take & (link.wdata == `CMD_DEV_RESET);
  wire [7:0] cmd_even = {link.wdata[7:1], 1'b0};
  wire reg_sel_t cmd_sel = (cmd_even == `CMD_HWCFG_WR) ? SEL_HW :
                           (cmd_even == `CMD_IRQEN_WR) ? SEL_IE :
                           (cmd_even == `CMD_MODE_WR) ? SEL_MODE : SEL_NONE;
  // write codes are even, read codes odd
  wire cmd_is_wr = ~link.wdata[0];
  wire [1:0] last_idx = (sel_r == SEL_IE) ? 2'h3 : (sel_r == SEL_HW) ? 2'h1 : 2'h0;
  // bytes past the register length are acked but change nothing
  wire put_ok = data_wr & dir_wr_r & in_range_r & (sel_r != SEL_NONE);
  wire get_ok = data_rd & ~dir_wr_r & in_range_r & (sel_r != SEL_NONE);
  wire [31:0] cur_word = (sel_r == SEL_IE) ? ie_r :
                         (sel_r == SEL_HW) ? {16'h0000, hwcfg_r} : {24'h00_0000, mode_r};
  wire [31:0] wr_word = put_byte(cur_word, idx_r, link.wdata);
  wire byte_t rd_byte = get_byte(cur_word, idx_r);
  // suspend starts on the one-to-zero write of the trigger bit
  wire susp_go = put_ok & (sel_r == SEL_MODE) & mode_r[`MODE_SUSPEND_TRIGGER] &
                 ~link.wdata[`MODE_SUSPEND_TRIGGER];

  // ****************************************
  // configuration storage
  // ****************************************
  // usb bus reset is deliberately absent here: only hardware or command reset restores
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hwcfg_r <= `HW_RESET;
      ie_r <= `IE_RESET;
      mode_r <= `MODE_RESET;
    end else if (soft_reset) begin
      hwcfg_r <= `HW_RESET;
      ie_r <= `IE_RESET;
      mode_r <= `MODE_RESET;
    end else if (put_ok) begin
      // every bit is stored as written, reserved ones too
      if (sel_r == SEL_HW) hwcfg_r <= wr_word[15:0];
      if (sel_r == SEL_IE) ie_r <= wr_word;
      if (sel_r == SEL_MODE) mode_r <= wr_word[7:0];
    end
  end

  // ****************************************
  // command tracking and answers
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_r <= SEL_NONE;
      dir_wr_r <= 1'b0;
      idx_r <= 2'h0;
      in_range_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= link.req;
      if (cmd_take) begin
        sel_r <= cmd_sel;
        dir_wr_r <= cmd_is_wr;
        idx_r <= 2'h0;
        in_range_r <= 1'b1;
      end else if (data_wr | data_rd) begin
        idx_r <= idx_r + 2'h1;
        in_range_r <= in_range_r & (idx_r != last_idx);
      end
      if (data_rd) rdata_r <= get_ok ? rd_byte : 8'h00;
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;

  // ****************************************
  // suspend sequencing
  // ****************************************
  logic susp_r;
  logic [18:0] dly_r;
  logic done_r;
  logic [9:0] lazy_cnt_r;
  logic lazy_r;
  logic wake_r;

  wire wake = susp_r & hwcfg_r[`HW_WAKE_ON_SELECT] & ~i_cs_n & i_vbus;
  wire leave = i_usb_resume | i_usb_bus_reset | wake | soft_reset;
  wire lazy_wrap = (lazy_cnt_r == 10'(`LAZY_HALF_CYC - 1));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      susp_r <= 1'b0;
      dly_r <= 19'h0_0000;
      done_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake;
      if (leave) begin
        susp_r <= 1'b0;
        dly_r <= 19'h0_0000;
        done_r <= 1'b0;
      end else if (susp_go) begin
        susp_r <= 1'b1;
        dly_r <= 19'h0_0000;
        done_r <= 1'b0;
      end else if (susp_r && !done_r) begin
        dly_r <= dly_r + 19'h0_0001;
        done_r <= (dly_r == 19'(SUSPEND_DELAY_CYC - 1));
      end
    end
  end

  // slow clock runs only once the suspend delay has passed
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lazy_cnt_r <= 10'h000;
      lazy_r <= 1'b0;
    end else if (!done_r) begin
      lazy_cnt_r <= 10'h000;
      lazy_r <= 1'b0;
    end else begin
      lazy_cnt_r <= lazy_wrap ? 10'h000 : lazy_cnt_r + 10'h001;
      if (lazy_wrap) lazy_r <= ~lazy_r;
    end
  end

  // ****************************************
  // clock output
  // ****************************************
  logic div_clk;
  logic clock_output_pin_r;
  logic stopped_r;
  wire clocks_stop = done_r & ~hwcfg_r[`HW_CLOCKS_ALWAYS_ON];

  clk_out_div i_clk_out_div (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(~clocks_stop),
    .i_ref_tick(i_ref_tick),
    .i_div(hwcfg_r[`HW_DIV_HI:`HW_DIV_LO]),
    .o_clk(div_clk)
  );

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clock_output_pin_r <= 1'b0;
      stopped_r <= 1'b0;
    end else begin
      stopped_r <= clocks_stop;
      clock_output_pin_r <= done_r ? (~hwcfg_r[`HW_SLOW_CLOCK_DISABLE] & lazy_r) : div_clk;
    end
  end

  // ****************************************
  // interrupt pin
  // ****************************************
  logic pend_r;
  logic [5:0] pulse_cnt_r;
  logic irq_r;
  wire pend = mode_r[`MODE_GLOBAL_IRQ_ENABLE] &
              (|(i_irq_events & ie_r[23:0] & `IE_USED_MASK));
  wire pulse_mode = hwcfg_r[`HW_IRQ_PULSE_MODE];
  wire irq_active = pulse_mode ? (pulse_cnt_r != 6'h00) : pend_r;

  // a new pulse needs the pending condition to go away first
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_r <= 1'b0;
      pulse_cnt_r <= 6'h00;
      irq_r <= 1'b1;
    end else begin
      pend_r <= pend;
      if (pulse_mode && pend && !pend_r) pulse_cnt_r <= 6'(`IRQ_PULSE_CYC);
      else if (pulse_cnt_r != 6'h00) pulse_cnt_r <= pulse_cnt_r - 6'h01;
      irq_r <= ~(irq_active ^ hwcfg_r[`HW_IRQ_POLARITY]);
    end
  end

  // ****************************************
  // dma pins, pull-up and suspend pin
  // ****************************************
  logic dma_request_line_r;
  logic dma_ack_line_r;
  logic eot_r;
  logic pullup_r;
  logic susp_pin_r;
  // request line is idle in ack-only mode
  wire dma_request_line_act = i_dma_req & ~hwcfg_r[`HW_ACK_ONLY_DMA_MODE];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dma_request_line_r <= 1'b0;
      dma_ack_line_r <= 1'b0;
      eot_r <= 1'b0;
      pullup_r <= 1'b0;
      susp_pin_r <= 1'b0;
    end else begin
      dma_request_line_r <= ~(dma_request_line_act ^ hwcfg_r[`HW_DMA_REQUEST_POLARITY]);
      dma_ack_line_r <= ~(i_dma_ack_line ^ hwcfg_r[`HW_DMA_ACK_POLARITY]);
      eot_r <= ~(i_end_of_transfer_line ^ hwcfg_r[`HW_END_OF_TRANSFER_POLARITY]);
      pullup_r <= mode_r[`MODE_SOFT_ATTACH_ENABLE] &
                  ~hwcfg_r[`HW_EXTERNAL_PULLUP_SELECT];
      susp_pin_r <= susp_r & hwcfg_r[`HW_SUSPEND_POWER_OFF];
    end
  end

  assign o_clock_output_pin = clock_output_pin_r;
  assign o_dp_pullup_en = pullup_r;
  assign o_external_pullup = hwcfg_r[`HW_EXTERNAL_PULLUP_SELECT];
  assign o_ack_only_dma = hwcfg_r[`HW_ACK_ONLY_DMA_MODE];
  assign o_suspend_pin = susp_pin_r;
  assign o_suspended = susp_r;
  assign o_clocks_stopped = stopped_r;
  assign o_remote_wakeup = wake_r;
  assign o_irq_line = irq_r;
  assign o_dma_request_line = dma_request_line_r;
  assign o_dma_ack_active = dma_ack_line_r;
  assign o_transfer_end = eot_r;
endmodule : usb_cfg_dev

// ### usb_cfg_host.sv
//
// Purpose: controller end: wishbone registers turned into link command sequences
// Assumes: device acks each link byte
// Notes: byte counts follow the command code
//
`timescale 1ns/100ps
`include "usb_cfg_map.svh"
module usb_cfg_host (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  usb_cfg_link_if.host link
);
  import usb_cfg_pkg::*;

  function automatic logic [2:0] cmd_len(input byte_t c);
    case ({c[7:1], 1'b0})
      `CMD_HWCFG_WR: cmd_len = 3'h2;
      `CMD_IRQEN_WR: cmd_len = 3'h4;
      `CMD_MODE_WR: cmd_len = 3'h1;
      default: cmd_len = 3'h0;
    endcase
  endfunction : cmd_len

  // ****************************************
  // wishbone slave
  // ****************************************
  host_state_t state_r;
  byte_t cmd_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic done_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [2:0] pos_r;
  logic [2:0] len_r;
  logic req_r;
  logic is_cmd_r;
  logic wr_r;
  byte_t out_r;

  wire wb_req = i_wb_cyc & i_wb_stb & ~ack_r;
  wire wb_wr = wb_req & i_wb_we;
  wire busy = (state_r != H_IDLE);
  // writes to the command register while busy are dropped
  wire start = wb_wr & (i_wb_adr == `HOST_CTRL) & i_wb_sel[0] & ~busy;
  wire [31:0] rd_mux = (i_wb_adr == `HOST_CTRL) ? {24'h00_0000, cmd_r} :
                       (i_wb_adr == `HOST_WDATA) ? wdata_r :
                       (i_wb_adr == `HOST_RDATA) ? rdata_r :
                       (i_wb_adr == `HOST_STATUS) ? {30'h0000_0000, done_r, busy} : 32'h0000_0000;
  wire [1:0] bidx = 2'(pos_r - 3'h1);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !i_wb_we) dat_r <= rd_mux;
      if (wb_wr && i_wb_adr == `HOST_WDATA) begin
        for (int b = 0; b < 4; b++) begin
          if (i_wb_sel[b]) wdata_r[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
        end
      end
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = dat_r;

  // ****************************************
  // link sequencer
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= H_IDLE;
      cmd_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      done_r <= 1'b0;
      pos_r <= 3'h0;
      len_r <= 3'h0;
      req_r <= 1'b0;
      is_cmd_r <= 1'b0;
      wr_r <= 1'b0;
      out_r <= 8'h00;
    end else begin
      case (state_r)
        H_IDLE: begin
          req_r <= 1'b0;
          if (start) begin
            cmd_r <= i_wb_dat[7:0];
            len_r <= cmd_len(i_wb_dat[7:0]);
            pos_r <= 3'h0;
            done_r <= 1'b0;
            state_r <= H_SEND;
          end
        end
        H_SEND: begin
          req_r <= 1'b1;
          is_cmd_r <= (pos_r == 3'h0);
          wr_r <= (pos_r != 3'h0) & ~cmd_r[0];
          out_r <= (pos_r == 3'h0) ? cmd_r : get_byte(wdata_r, bidx);
          state_r <= H_WAIT;
        end
        H_WAIT: begin
          req_r <= 1'b0;
          if (link.ack) begin
            if (pos_r != 3'h0 && cmd_r[0]) rdata_r <= put_byte(rdata_r, bidx, link.rdata);
            if (pos_r == len_r) begin
              done_r <= 1'b1;
              state_r <= H_IDLE;
            end else begin
              pos_r <= pos_r + 3'h1;
              state_r <= H_SEND;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.req = req_r;
  assign link.is_cmd = is_cmd_r;
  assign link.wr = wr_r;
  assign link.wdata = out_r;
endmodule : usb_cfg_host

// ### usb_cfg_monitor.sv
// Purpose: link protocol checks between the controller and device ends
// Assumes: one clock, asynchronous active-low reset
// Notes: watches the link signals only
`timescale 1ns/100ps
`include "usb_cfg_map.svh"
module usb_cfg_monitor (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic req,
  input wire logic is_cmd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // ****
  // data bytes since the last command
  // ****
  logic [2:0] len_r;
  logic [2:0] cnt_r;
  wire logic cmd_req = req && is_cmd;
  // mode and unknown codes give 0, so their counts go unchecked
  wire logic [2:0] len_nxt = (wdata[7:1] == 7'h5D) ? 3'h2 : (wdata[7:1] == 7'h61) ? 3'h4 : 3'h0;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      len_r <= 3'h0;
      cnt_r <= 3'h0;
    end else if (cmd_req) begin
      len_r <= len_nxt;
      cnt_r <= 3'h0;
    end else if (req) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // ****
  // properties
  // ****
  sequence s_cmd(logic [7:0] code);
    cmd_req && wdata == code;
  endsequence
  sequence s_wr_byte;
    req && !is_cmd && wr;
  endsequence
  property p_ack_after_req;
    req |=> ack;
  endproperty
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  property p_req_gap;
    req |=> !req [*2];
  endproperty
  property p_hw_wr;
    s_cmd(`CMD_HWCFG_WR) |-> ##[3:20] s_wr_byte;
  endproperty
  property p_ie_wr;
    s_cmd(`CMD_IRQEN_WR) |-> ##[3:20] s_wr_byte;
  endproperty
  property p_byte_count;
    cmd_req && len_r != 3'h0 |-> cnt_r == len_r;
  endproperty
  property p_rdata_hold;
    $changed(rdata) |-> ack;
  endproperty
  property p_wdata_hold;
    $changed(wdata) |-> req;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req)
    else $error("link ack missing");
  a_ack_cause: assert property (p_ack_cause)
    else $error("link ack without request");
  a_req_gap: assert property (p_req_gap)
    else $error("link requests too close");
  a_hw_wr: assert property (p_hw_wr)
    else $error("hwcfg write has no data byte");
  a_ie_wr: assert property (p_ie_wr)
    else $error("irq enable write has no data byte");
  a_byte_count: assert property (p_byte_count)
    else $error("wrong data byte count");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read byte changed without ack");
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write byte changed without request");
endmodule : usb_cfg_monitor

// ### usb_dev_hwcfg_irq_enable_regs_test.sv
// Purpose: both ends joined, driven over wishbone, pins checked
// Assumes: reference tick every 4 clocks, short suspend delay
// Notes: expected values come from the register layout
`timescale 1ns/100ps
`include "usb_cfg_map.svh"
module usb_dev_hwcfg_irq_enable_regs_test;
  import usb_cfg_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wb_ack;
  logic ref_tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  irq_vec_t events = 24'h0;
  logic bus_rst = 1'b0;
  logic resume = 1'b0;
  logic vbus = 1'b1;
  logic cs_n = 1'b1;
  logic dma_req = 1'b1;
  logic dma_ack_line = 1'b1;
  logic end_of_transfer_line = 1'b1;
  logic clk_pin, pullup_en, ext_pu, ack_only, susp_pin, suspended, clk_stop;
  logic irq_line, dma_request_line_line, dma_ack_line_act, eot_act, wakeup;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] q;
  usb_cfg_link_if link ();
  usb_cfg_host i_usb_cfg_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(wb_ack), .link(link));
  usb_cfg_dev #(.SUSPEND_DELAY_CYC(20)) i_usb_cfg_dev (.i_clk(i_clk), .i_resetn(i_resetn),
    .link(link), .i_ref_tick(ref_tick), .i_irq_events(events), .i_usb_bus_reset(bus_rst),
    .i_usb_resume(resume), .i_vbus(vbus), .i_cs_n(cs_n), .i_dma_req(dma_req),
    .i_dma_ack_line(dma_ack_line), .i_end_of_transfer_line(end_of_transfer_line), .o_clock_output_pin(clk_pin),
    .o_dp_pullup_en(pullup_en), .o_external_pullup(ext_pu), .o_ack_only_dma(ack_only),
    .o_suspend_pin(susp_pin), .o_suspended(suspended), .o_clocks_stopped(clk_stop),
    .o_remote_wakeup(wakeup), .o_irq_line(irq_line), .o_dma_request_line(dma_request_line_line),
    .o_dma_ack_active(dma_ack_line_act), .o_transfer_end(eot_act));
  usb_cfg_monitor i_usb_cfg_monitor (.i_clk(i_clk), .i_resetn(i_resetn), .req(link.req),
    .is_cmd(link.is_cmd), .wr(link.wr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata));
  // ****
  // clock, reference tick and timeout
  // ****
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    ref_tick <= (tick_cnt == 2'h3);
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ****
  // tasks
  // ****
  task wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task reg_chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : reg_chk
  task pin_chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : pin_chk
  // request held until ack is sampled high, read data taken at that edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clk); while (wb_ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task xfer(input logic [7:0] code, input logic [31:0] d, output logic [31:0] r);
    logic [31:0] s;
    int n;
    wb(1'b1, `HOST_WDATA, d, s);
    wb(1'b1, `HOST_CTRL, {24'h0, code}, s);
    n = 0;
    do begin
      wb(1'b0, `HOST_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 40);
    pin_chk("link busy", 1'b0, s[0]);
    wb(1'b0, `HOST_RDATA, 32'h0, r);
  endtask : xfer
  task rd(input logic [7:0] code, input string nm, input logic [31:0] e);
    logic [31:0] m;
    m = (code == `CMD_IRQEN_RD) ? 32'hFFFFFFFF : 32'h0000FFFF;
    xfer(code, 32'h0, q);
    reg_chk(nm, e, q & m);
  endtask : rd
  task measure(output logic [31:0] p);
    realtime t0;
    repeat (2) @(posedge clk_pin);
    t0 = $realtime;
    @(posedge clk_pin);
    p = 32'(int'(($realtime - t0) / 5.0));
  endtask : measure
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] p;
    int n;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk);
    pin_chk("irq idle", 1'b1, irq_line);
    pin_chk("dma_request_line high", 1'b1, dma_request_line_line);
    rd(`CMD_HWCFG_RD, "hwcfg", 32'h2340);
    rd(`CMD_IRQEN_RD, "irq enable", 32'h0);
    wb(1'b0, 8'h10, 32'h0, q);
    reg_chk("unmapped", 32'h0, q);
    measure(p);
    reg_chk("clk period", 32'h10, p);
    xfer(`CMD_HWCFG_WR, 32'hC1B5, q);
    rd(`CMD_HWCFG_RD, "hwcfg", 32'hC1B5);
    pin_chk("ext pullup", 1'b1, ext_pu);
    pin_chk("ack only", 1'b1, ack_only);
    pin_chk("dma_request_line held", 1'b1, dma_request_line_line);
    pin_chk("irq high pol", 1'b0, irq_line);
    pin_chk("dma_ack_line", 1'b1, dma_ack_line_act);
    pin_chk("eot", 1'b1, eot_act);
    measure(p);
    reg_chk("clk period", 32'h08, p);
    xfer(`CMD_MODE_WR, 32'h01, q);
    pin_chk("attach ext", 1'b0, pullup_en);
    xfer(`CMD_HWCFG_WR, 32'h030C, q);
    pin_chk("attach own", 1'b1, pullup_en);
    pin_chk("dma_request_line low pol", 1'b0, dma_request_line_line);
    xfer(`CMD_IRQEN_WR, 32'hA5C30F21, q);
    bus_rst <= 1'b1;
    @(posedge i_clk);
    bus_rst <= 1'b0;
    rd(`CMD_HWCFG_RD, "hwcfg", 32'h030C);
    rd(`CMD_IRQEN_RD, "irq enable", 32'hA5C30F21);
    events <= 24'h000001;
    repeat (3) @(posedge i_clk);
    pin_chk("irq gated", 1'b1, irq_line);
    xfer(`CMD_MODE_WR, 32'h09, q);
    pin_chk("irq level", 1'b0, irq_line);
    events <= 24'h000000;
    xfer(`CMD_HWCFG_WR, 32'h030F, q);
    events <= 24'h000100;
    n = 0;
    while (irq_line !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    p = 32'h0;
    while (irq_line === 1'b1 && p < 32'h64) begin
      @(posedge i_clk);
      p++;
    end
    reg_chk("irq pulse", 32'h22, p);
    xfer(`CMD_MODE_WR, 32'h29, q);
    xfer(`CMD_MODE_WR, 32'h09, q);
    pin_chk("suspended", 1'b1, suspended);
    pin_chk("power pin", 1'b1, susp_pin);
    repeat (25) @(posedge i_clk);
    pin_chk("clocks stopped", 1'b1, clk_stop);
    // slow suspend clock: 100 kHz is 2000 cycles of the 200 MHz clock
    measure(p);
    reg_chk("slow clk period", 32'h7D0, p);
    cs_n <= 1'b0;
    n = 0;
    while (suspended !== 1'b0 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    pin_chk("woken", 1'b0, suspended);
    pin_chk("wake pulse", 1'b1, wakeup);
    cs_n <= 1'b1;
    xfer(`CMD_DEV_RESET, 32'h0, q);
    rd(`CMD_HWCFG_RD, "hwcfg", 32'h2340);
    rd(`CMD_IRQEN_RD, "irq enable", 32'h0);
    wrap_up();
  end
endmodule : usb_dev_hwcfg_irq_enable_regs_test
